// *** lbe_cfg.svh ***
/*
 constants for the logic and branch-equal execute block: opcodes,
 field positions, reset values.
 assumes it is included by its bare name wherever these are needed.
*/
`ifndef LBE_CFG_SVH
`define LBE_CFG_SVH

// ---------------------------------------------------------------
// opcodes
// ---------------------------------------------------------------
`define LBE_OP_RTYPE 6'h3A
`define LBE_OPX_AND 6'h0E
`define LBE_OP_ANDHI 6'h2C
`define LBE_OP_AND_IMMEDIATE_ZERO_EXTENDED 6'h0C
`define LBE_OP_BEQ 6'h26

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define LBE_A_HI 31
`define LBE_A_LO 27
`define LBE_B_HI 26
`define LBE_B_LO 22
`define LBE_IMM_HI 21
`define LBE_IMM_LO 6
`define LBE_OP_HI 5
`define LBE_OP_LO 0
`define LBE_C_HI 21
`define LBE_C_LO 17
`define LBE_OPX_HI 16
`define LBE_OPX_LO 11
`define LBE_SH_HI 10
`define LBE_SH_LO 6

// ---------------------------------------------------------------
// values
// ---------------------------------------------------------------
`define LBE_PC_STEP 32'h0000_0004
`define LBE_HALF_ZERO 16'h0000
`define LBE_SH_ZERO 5'h00
`define LBE_WORD_RST 32'h0000_0000
`define LBE_IDX_RST 5'h00
`define LBE_REG_COUNT 32

`endif

// *** lbe_pkg.sv ***
/*
 types for the logic and branch-equal execute block.
 assumes nothing beyond a SystemVerilog compiler.
*/
package lbe_pkg;
   typedef enum logic [2:0] {
      LBE_IDLE = 3'b001,
      LBE_READ = 3'b010,
      LBE_EXEC = 3'b100
   } lbe_state_e;
   typedef logic [31:0] lbe_word_t;
   typedef logic [4:0] lbe_idx_t;
endpackage

// *** lbe_regfile.sv ***
/*
 general-purpose register store: two read ports with registered
 data, one write port.
 assumes a single clock and that the owner arbitrates the write port.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lbe_cfg.svh"
module lbe_regfile (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [4:0] rd_a_idx,
   input wire logic [4:0] rd_b_idx,
   output logic [31:0] rd_a_data,
   output logic [31:0] rd_b_data,
   input wire logic wr_en,
   input wire logic [4:0] wr_idx,
   input wire logic [31:0] wr_data
);
   logic [31:0] mem_q [`LBE_REG_COUNT];
   logic [31:0] rd_a_d;
   logic [31:0] rd_b_d;

   // ---------------------------------------------------------------
   // storage, one generate entry per register
   // ---------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `LBE_REG_COUNT; gi++) begin : g_ent
         logic [31:0] ent_d;
         always_comb begin
            ent_d = mem_q[gi];
            if (wr_en && (wr_idx == 5'(gi))) begin
               ent_d = wr_data;
            end
         end
         always_ff @(posedge core_clk or posedge sys_rst) begin
            if (sys_rst) begin
               mem_q[gi] <= `LBE_WORD_RST;
            end else begin
               mem_q[gi] <= ent_d;
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // registered read
   // ---------------------------------------------------------------
   always_comb begin
      rd_a_d = mem_q[rd_a_idx];
      rd_b_d = mem_q[rd_b_idx];
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_a_data <= `LBE_WORD_RST;
         rd_b_data <= `LBE_WORD_RST;
      end else begin
         rd_a_data <= rd_a_d;
         rd_b_data <= rd_b_d;
      end
   end
endmodule
`default_nettype wire

// *** lbe_exec.sv ***
/*
 decode and execute of register AND, AND-immediate high and low, and
 branch-if-equal, with its own register store.
 assumes instructions arrive one at a time with their program counter
 and that the caller waits for done before offering the next.
*/
// How it works
// - register AND writes first AND second source into the result register.
// - register AND is opcode 0x3a, extended 0x0e, small field zero.
// - high AND-immediate puts immediate in bits 31..16, zeros below, writes B.
// - high AND-immediate field is unsigned, never sign extended.
// - branch taken only when both sources are equal, else sequential.
// - taken target is pc plus 4 plus signed offset; else pc plus 4.
// - misaligned branch target raises an exception; AND forms never do.
// - branch-if-equal is I-type opcode 0x26 with signed offset.
`timescale 1ns/1ps
`default_nettype none
`include "lbe_cfg.svh"
module lbe_exec (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic instr_valid,
   input wire logic [31:0] instr_word,
   input wire logic [31:0] instr_pc,
   output logic instr_ready,
   output logic done,
   output logic [31:0] next_pc,
   output logic branch_taken,
   output logic misalign_exc,
   output logic unsupported,
   output logic wb_en,
   output logic [4:0] wb_idx,
   output logic [31:0] wb_data,
   input wire logic load_en,
   input wire logic [4:0] load_idx,
   input wire logic [31:0] load_data
);
   lbe_pkg::lbe_state_e state_q;
   lbe_pkg::lbe_state_e state_d;
   logic [31:0] word_q;
   logic [31:0] word_d;
   logic [31:0] pc_q;
   logic [31:0] pc_d;
   logic ready_d;
   logic done_d;
   logic taken_d;
   logic exc_d;
   logic unsup_d;
   logic wb_en_d;
   logic [31:0] next_pc_d;
   logic [31:0] wb_data_d;
   logic [4:0] wb_idx_d;
   logic [31:0] src_a;
   logic [31:0] src_b;
   logic [4:0] idx_a;
   logic [4:0] idx_b;
   logic [4:0] idx_c;
   logic [5:0] opcode;
   logic [5:0] opx;
   logic [15:0] sixteen_bit_immediate_field;
   logic [4:0] sh5;
   logic [31:0] seq_pc;
   logic [31:0] target;
   logic [31:0] imm_hi;
   logic [31:0] imm_lo;
   logic is_and;
   logic is_andhi;
   logic is_and_immediate_zero_extended;
   logic is_beq;
   logic rf_wr_en;
   logic [4:0] rf_wr_idx;
   logic [31:0] rf_wr_data;

   // ---------------------------------------------------------------
   // field decode
   // ---------------------------------------------------------------
   always_comb begin
      idx_a = word_q[`LBE_A_HI:`LBE_A_LO];
      idx_b = word_q[`LBE_B_HI:`LBE_B_LO];
      idx_c = word_q[`LBE_C_HI:`LBE_C_LO];
      sixteen_bit_immediate_field =
         word_q[`LBE_IMM_HI:`LBE_IMM_LO];
      opcode = word_q[`LBE_OP_HI:`LBE_OP_LO];
      opx = word_q[`LBE_OPX_HI:`LBE_OPX_LO];
      sh5 = word_q[`LBE_SH_HI:`LBE_SH_LO];
      // a nonzero small field makes the word unknown, not a plain AND
      is_and = (opcode == `LBE_OP_RTYPE) && (opx == `LBE_OPX_AND)
         && (sh5 == `LBE_SH_ZERO);
      is_andhi = (opcode == `LBE_OP_ANDHI);
      is_and_immediate_zero_extended =
         (opcode == `LBE_OP_AND_IMMEDIATE_ZERO_EXTENDED);
      is_beq = (opcode == `LBE_OP_BEQ);
      imm_hi = {sixteen_bit_immediate_field,
         `LBE_HALF_ZERO};
      imm_lo = {`LBE_HALF_ZERO, sixteen_bit_immediate_field};
      seq_pc = pc_q + `LBE_PC_STEP;
      // offset is used as printed; a producer slip in its low bits
      // surfaces as the misalignment exception, not silent rounding
      target = seq_pc + {{16{sixteen_bit_immediate_field[15]}},
         sixteen_bit_immediate_field};
   end

   // ---------------------------------------------------------------
   // sequencing and results
   // ---------------------------------------------------------------
   // ready only returns the cycle after done: the store takes the write-back
   // on the edge after done's, so an instruction taken next always reads fresh data
   always_comb begin
      state_d = state_q;
      word_d = word_q;
      pc_d = pc_q;
      ready_d = 1'b0;
      done_d = 1'b0;
      next_pc_d = next_pc;
      taken_d = branch_taken;
      exc_d = misalign_exc;
      unsup_d = unsupported;
      wb_en_d = 1'b0;
      wb_idx_d = wb_idx;
      wb_data_d = wb_data;
      case (state_q)
         lbe_pkg::LBE_IDLE: begin
            ready_d = 1'b1;
            if (instr_valid && instr_ready) begin
               word_d = instr_word;
               pc_d = instr_pc;
               ready_d = 1'b0;
               state_d = lbe_pkg::LBE_READ;
            end
         end
         lbe_pkg::LBE_READ: begin
            state_d = lbe_pkg::LBE_EXEC;
         end
         lbe_pkg::LBE_EXEC: begin
            done_d = 1'b1;
            next_pc_d = seq_pc;
            taken_d = 1'b0;
            exc_d = 1'b0;
            unsup_d = 1'b0;
            if (is_and) begin
               wb_en_d = 1'b1;
               wb_idx_d = idx_c;
               wb_data_d = src_a & src_b;
            end else if (is_andhi) begin
               wb_en_d = 1'b1;
               wb_idx_d = idx_b;
               wb_data_d = src_a & imm_hi;
            end else if (is_and_immediate_zero_extended) begin
               wb_en_d = 1'b1;
               wb_idx_d = idx_b;
               wb_data_d = src_a & imm_lo;
            end else if (is_beq) begin
               if (src_a == src_b) begin
                  taken_d = 1'b1;
                  next_pc_d = target;
                  exc_d = (target[1:0] != 2'b00);
               end
            end else begin
               // unknown words still step to pc plus 4 so a caller
               // can skip them; nothing is written back
               unsup_d = 1'b1;
            end
            state_d = lbe_pkg::LBE_IDLE;
         end
         default: begin
            state_d = lbe_pkg::LBE_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= lbe_pkg::LBE_IDLE;
         word_q <= `LBE_WORD_RST;
         pc_q <= `LBE_WORD_RST;
         instr_ready <= 1'b0;
         done <= 1'b0;
         next_pc <= `LBE_WORD_RST;
         branch_taken <= 1'b0;
         misalign_exc <= 1'b0;
         unsupported <= 1'b0;
         wb_en <= 1'b0;
         wb_idx <= `LBE_IDX_RST;
         wb_data <= `LBE_WORD_RST;
      end else begin
         state_q <= state_d;
         word_q <= word_d;
         pc_q <= pc_d;
         instr_ready <= ready_d;
         done <= done_d;
         next_pc <= next_pc_d;
         branch_taken <= taken_d;
         misalign_exc <= exc_d;
         unsupported <= unsup_d;
         wb_en <= wb_en_d;
         wb_idx <= wb_idx_d;
         wb_data <= wb_data_d;
      end
   end

   // ---------------------------------------------------------------
   // register store access
   // ---------------------------------------------------------------
   // write-back owns the port; a load in the same cycle is dropped,
   // which keeps one writer per edge without a queue
   always_comb begin
      rf_wr_en = wb_en | load_en;
      rf_wr_idx = wb_en ? wb_idx : load_idx;
      rf_wr_data = wb_en ? wb_data : load_data;
   end

   lbe_regfile u_rf (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .rd_a_idx(idx_a),
      .rd_b_idx(idx_b),
      .rd_a_data(src_a),
      .rd_b_data(src_b),
      .wr_en(rf_wr_en),
      .wr_idx(rf_wr_idx),
      .wr_data(rf_wr_data)
   );
endmodule
`default_nettype wire

// *** lbe_exec_checker.sv ***
/*
 assertions on the ports of lbe_exec.
 assumes a bind from the bench and the cfg header on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lbe_cfg.svh"
module lbe_exec_checker (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic instr_valid,
   input wire logic [31:0] instr_word,
   input wire logic [31:0] instr_pc,
   input wire logic instr_ready,
   input wire logic done,
   input wire logic [31:0] next_pc,
   input wire logic branch_taken,
   input wire logic misalign_exc,
   input wire logic unsupported,
   input wire logic wb_en,
   input wire logic [4:0] wb_idx,
   input wire logic [31:0] wb_data,
   input wire logic load_en,
   input wire logic [4:0] load_idx,
   input wire logic [31:0] load_data
);
   // ---------------------------------------------------------------
   // capture of the taken word, so results can be tied to their cause
   // ---------------------------------------------------------------
   logic [31:0] pc_q, wd_q;
   logic tk;
   assign tk = instr_valid && instr_ready;
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pc_q <= 32'h0;
         wd_q <= 32'h0;
      end else if (tk) begin
         pc_q <= instr_pc;
         wd_q <= instr_word;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   AST_LAT: assert property (tk |=> !instr_ready && !done ##1 !done ##1
      done) else $error("done latency wrong");
   AST_PULSE: assert property (done |=> !done && !wb_en)
      else $error("done not a pulse");
   AST_WBD: assert property (wb_en |-> done && !misalign_exc &&
      !branch_taken) else $error("write with branch state");
   AST_SEQ: assert property (done && !branch_taken |->
      next_pc == pc_q + 32'h4) else $error("sequential pc wrong");
   AST_TGT: assert property (done && branch_taken |-> next_pc ==
      pc_q + 32'h4 + {{16{wd_q[21]}}, wd_q[21:6]}) else $error("target");
   AST_MIS: assert property (done |-> misalign_exc ==
      (branch_taken && next_pc[1:0] != 2'h0)) else $error("misalign");
   AST_BEQ: assert property (done && wd_q[5:0] == `LBE_OP_BEQ |->
      !wb_en && !unsupported) else $error("branch decode");
   AST_RIDX: assert property (wb_en && wd_q[5:0] == `LBE_OP_RTYPE |->
      wb_idx == wd_q[21:17]) else $error("result index");
   AST_IIDX: assert property (wb_en && wd_q[5:0] != `LBE_OP_RTYPE |->
      wb_idx == wd_q[26:22]) else $error("immediate dest index");
   cover property (wb_en && wd_q[5:0] == `LBE_OP_RTYPE);
   cover property (done && branch_taken);
   cover property (done && misalign_exc);
endmodule
`default_nettype wire

// *** logic_and_branch_equal_exec_tb.sv ***
/*
 random self-checking bench for lbe_exec against a register model.
 assumes the cfg header, the design and the checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lbe_cfg.svh"
`define CHK(a, b, m) begin comparisons++; if ((a) !== (b)) begin \
   error_cnt++; $display("MISMATCH %0t %s", $time, m); end end
module logic_and_branch_equal_exec_tb;
   logic core_clk = 1'b0, sys_rst = 1'b1, instr_valid = 1'b0, load_en = 1'b0;
   logic [31:0] instr_word = 32'h0, instr_pc = 32'h0, load_data = 32'h0;
   logic [4:0] load_idx = 5'h00;
   logic instr_ready, done, branch_taken, misalign_exc, unsupported, wb_en;
   logic [31:0] next_pc, wb_data, r, w, rf [32];
   logic [4:0] wb_idx;
   int error_cnt = 0, comparisons = 0, seed = 32'h2885;
   lbe_exec u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
      .instr_valid(instr_valid), .instr_word(instr_word),
      .instr_pc(instr_pc), .instr_ready(instr_ready), .done(done),
      .next_pc(next_pc), .branch_taken(branch_taken),
      .misalign_exc(misalign_exc), .unsupported(unsupported),
      .wb_en(wb_en), .wb_idx(wb_idx), .wb_data(wb_data),
      .load_en(load_en), .load_idx(load_idx), .load_data(load_data));
   initial forever #5 core_clk = ~core_clk;
   task close_out();
      if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // loads only between instructions, where wb_en is low
   task ld(input logic [4:0] i, input logic [31:0] d);
      @(posedge core_clk);
      load_en <= 1'b1;
      load_idx <= i;
      load_data <= d;
      rf[i] = d;
      @(posedge core_clk);
      load_en <= 1'b0;
   endtask
   task run(input logic [31:0] iw, input logic [31:0] pc);
      logic [31:0] a, b, xpc, xd;
      logic [4:0] xi;
      logic xw, xt, xu;
      a = rf[iw[31:27]];
      b = rf[iw[26:22]];
      {xw, xt, xu, xd, xi, xpc} = {3'h0, 32'h0, iw[26:22], pc + 32'h4};
      case (iw[5:0])
         `LBE_OP_RTYPE: begin
            xu = iw[16:11] != `LBE_OPX_AND || iw[10:6] != 5'h00;
            {xw, xd, xi} = {!xu, a & b, iw[21:17]};
         end
         `LBE_OP_ANDHI: {xw, xd} = {1'b1, a & {iw[21:6], 16'h0000}};
         `LBE_OP_AND_IMMEDIATE_ZERO_EXTENDED: begin
            {xw, xd} = {1'b1, a & {16'h0000, iw[21:6]}};
         end
         `LBE_OP_BEQ: begin
            xt = a == b;
            if (xt) xpc = xpc + {{16{iw[21]}}, iw[21:6]};
         end
         default: xu = 1'b1;
      endcase
      @(posedge core_clk);
      {instr_valid, instr_word, instr_pc} <= {1'b1, iw, pc};
      @(posedge core_clk);
      while (instr_ready !== 1'b1) @(posedge core_clk);
      instr_valid <= 1'b0;
      @(posedge core_clk);
      while (done !== 1'b1) @(posedge core_clk);
      `CHK(wb_en, xw, "write enable")
      `CHK(unsupported, xu, "decode")
      if (xw) `CHK(wb_idx, xi, "dest index")
      if (xw) `CHK(wb_data, xd, "and result")
      `CHK(branch_taken, xt, "taken")
      `CHK(next_pc, xpc, "next pc")
      `CHK(misalign_exc, xt && xpc[1:0] != 2'h0, "misalign")
      if (xw) rf[xi] = xd;
   endtask
   initial begin
      repeat (6) @(posedge core_clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 32; i++) ld(5'(i), $random(seed));
      for (int n = 0; n < 400; n++) begin
         r = $random(seed);
         w = $random(seed);
         if (r[5]) ld(r[10:6], $random(seed));
         case (r[2:0])
            3'h0: begin
               {w[16:11], w[5:0]} = {`LBE_OPX_AND, `LBE_OP_RTYPE};
               if (r[4:3] != 2'h0) w[10:6] = 5'h00;
            end
            3'h1: w[5:0] = `LBE_OP_ANDHI;
            3'h2: w[5:0] = `LBE_OP_AND_IMMEDIATE_ZERO_EXTENDED;
            3'h3: w[5:0] = `LBE_OP_BEQ;
            3'h4: {w[26:22], w[5:0]} = {w[31:27], `LBE_OP_BEQ};
            3'h5: {w[26:22], w[7:0]} = {w[31:27], 2'h0, `LBE_OP_BEQ};
            default: ;
         endcase
         run(w, $random(seed) & 32'hFFFF_FFFC);
      end
      close_out();
   end
   // 400 instructions of at most about 10 cycles, with ample margin
   initial begin
      #200000;
      error_cnt++;
      close_out();
   end
endmodule
bind lbe_exec lbe_exec_checker u_chk (.core_clk(core_clk),
   .sys_rst(sys_rst), .instr_valid(instr_valid), .instr_word(instr_word),
   .instr_pc(instr_pc), .instr_ready(instr_ready), .done(done),
   .next_pc(next_pc), .branch_taken(branch_taken),
   .misalign_exc(misalign_exc), .unsupported(unsupported), .wb_en(wb_en),
   .wb_idx(wb_idx), .wb_data(wb_data), .load_en(load_en),
   .load_idx(load_idx), .load_data(load_data));
`undef CHK
`default_nettype wire
